/* File: bench/cfb_host_model.sv */
/*
  Host side of the two-wire enable port: start, stop and byte tasks.
  Assumes the bench resolves the data wire with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
module cfb_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // lines idle released, serial clock stands high outside frames
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end

  // all line changes land on falling edges of the system clock
  task automatic pause(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // data falls while the clock is high
  task automatic start();
    pause(5);
    o_sda_low = 1'h0;
    pause(15);
    o_scl = 1'h1;
    pause(20);
    o_sda_low = 1'h1;
    pause(20);
    o_scl = 1'h0;
  endtask

  // data rises while the clock is high
  task automatic stop();
    pause(5);
    o_sda_low = 1'h1;
    pause(15);
    o_scl = 1'h1;
    pause(20);
    o_sda_low = 1'h0;
    pause(20);
  endtask

  // data changes only five cycles into the low phase, well clear of the clock fall
  task automatic clk_bit(input logic low);
    pause(5);
    o_sda_low = low;
    pause(15);
    o_scl = 1'h1;
    pause(20);
    o_scl = 1'h0;
  endtask

  // eight bits most significant first, then release and sample the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i]);
    end
    pause(5);
    o_sda_low = 1'h0;
    pause(15);
    o_scl = 1'h1;
    pause(10);
    ack = ~i_sda;
    pause(10);
    o_scl = 1'h0;
  endtask
endmodule

/* File: bench/clock_fanout_serial_enable_tb.sv */
/*
  Self-checking bench: writes enables over the serial port and checks
  every gated output against the input clock.
  Assumes the host model above and a pulled-up data wire.
*/
`timescale 1ns/1ps
module clock_fanout_serial_enable_tb;
  import cfb_pkg::*;
  logic i_clk, i_rst, i_ref_clk, scl, host_low, sda, sd_o, sd_oe, fb;
  logic [NUM_MEM-1:0] mem;
  logic [7:0] cfg [3];
  int n_errors, comparisons;

  // pulled-up open-drain data wire
  assign sda = ~(host_low | (sd_oe & ~sd_o));

  // system clock 5 ns
  always #2.5 i_clk = ~i_clk;

  // link clock 48 ns, offset so edges never meet the system clock
  initial begin
    i_ref_clk = 1'h0;
    #1.1;
    forever #24 i_ref_clk = ~i_ref_clk;
  end

  cfb_host_model u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(host_low));

  cfb_fanout u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ref_clk(i_ref_clk),
    .i_serial_clock(scl), .i_serial_data_line(sda),
    .o_serial_data_line_o(sd_o), .o_serial_data_line_oe(sd_oe),
    .o_mem_clk(mem), .o_feedback_clock_output(fb));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [12:0] exp_en(input logic [7:0] b0, b1, b2);
    return {b2[6], b1[7:4], b1[1:0], b0[7:6], b0[3:0]};
  endfunction

  // high phase shows the enables, low phase shows nothing
  task automatic check_outs(input logic [12:0] exp);
    repeat (6) @(posedge i_ref_clk);
    #3 check({3'h0, fb, mem}, {3'h0, exp});
    @(negedge i_ref_clk);
    #3 check({3'h0, fb, mem}, 16'h0);
  endtask

  // reset spans three link clock edges; enables return to all set
  task automatic do_reset();
    i_rst = 1'h1;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_clk);
    i_rst = 1'h0;
    for (int k = 0; k < 3; k++) cfg[k] = CFG_RST;
    check_outs(EN_ALL);
  endtask

  // pat: 0 random, 1 all zero, 2 all one; reserved bits kept zero
  task automatic xfer(input logic [7:0] addr, input int n,
      input logic ok, input int pat);
    logic a;
    logic [7:0] d;
    u_host.start();
    u_host.send_byte(addr, a);
    check({15'h0, a}, {15'h0, ok});
    for (int k = 0; k < n; k++) begin
      d = pat == 1 ? 8'h00 : pat == 2 ? 8'hFF : 8'($urandom);
      d &= k == 0 ? 8'hCF : k == 1 ? 8'hF3 : k == 2 ? 8'h40 : 8'hFF;
      u_host.send_byte(d, a);
      check({15'h0, a}, {15'h0, ok});
      if (ok && k < 3) cfg[k] = d;
    end
    u_host.stop();
    check_outs(exp_en(cfg[0], cfg[1], cfg[2]));
  endtask

  initial begin
    #300000;
    n_errors++;
    results();
  end

  initial begin
    logic [6:0] bad;
    i_clk = 1'h0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'h2d58));
    do_reset();
    xfer({DEV_ADDR, DIR_WRITE}, 3, 1'h1, 1);
    xfer({DEV_ADDR, DIR_WRITE}, 3, 1'h1, 2);
    for (int t = 0; t < 6; t++) xfer({DEV_ADDR, DIR_WRITE}, 3, 1'h1, 0);
    xfer({DEV_ADDR, 1'h1}, 2, 1'h0, 1);
    for (int t = 0; t < 3; t++) begin
      bad = 7'($urandom);
      if (bad == DEV_ADDR) bad ^= 7'h01;
      xfer({bad, DIR_WRITE}, 2, 1'h0, 1);
    end
    xfer({DEV_ADDR, DIR_WRITE}, 1, 1'h1, 1);
    xfer({DEV_ADDR, DIR_WRITE}, 5, 1'h1, 0);
    do_reset();
    results();
  end

  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
endmodule

/* File: rtl/cfb_fanout.sv */
/*
  Thirteen-way clock fanout with per-output enables written over a
  two-wire serial slave (write only).
  Assumes the serial lines are sampled by i_clk at a rate well above the
  serial clock, and i_ref_clk is the free-running clock being fanned out.
*/
`timescale 1ns/1ps
module cfb_fanout
  import cfb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ref_clk,
  input wire logic i_serial_clock,
  input wire logic i_serial_data_line,
  output logic o_serial_data_line_o,
  output logic o_serial_data_line_oe,
  output logic [NUM_MEM-1:0] o_mem_clk,
  output logic o_feedback_clock_output
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  cfb_state_e state_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic [1:0] idx_r;
  logic oe_r;
  cfb_cfg_s cfg_r;
  logic [NUM_OUT-1:0] en_sys_r;
  logic written_r;
  logic [1:0] rst_ref_r;
  logic [NUM_OUT-1:0] en_m1_r;
  logic [NUM_OUT-1:0] en_m2_r;
  logic [NUM_OUT-1:0] gate_r;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic byte_done, addr_hit, ack_addr, ack_data, ack_end;

  // two-flop synchronisers, then one more stage for edge detection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'h1;
      sda_prev_r <= 1'h1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], i_serial_clock};
      sda_sync_r <= {sda_sync_r[0], i_serial_data_line};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  // line events; start and stop are data edges while the clock is high
  assign scl_rise = scl_sync_r[1] && !scl_prev_r;
  assign scl_fall = !scl_sync_r[1] && scl_prev_r;
  assign start_ev = scl_sync_r[1] && scl_prev_r && sda_prev_r && !sda_sync_r[1];
  assign stop_ev = scl_sync_r[1] && scl_prev_r && !sda_prev_r && sda_sync_r[1];
  assign byte_done = scl_fall && (cnt_r == BITS_PER_BYTE);
  assign addr_hit = (shift_r == {DEV_ADDR, DIR_WRITE});
  assign ack_addr = byte_done && (state_r == ST_ADDR) && addr_hit;
  assign ack_data = byte_done && (state_r == ST_DATA);
  assign ack_end = scl_fall &&
                   (state_r == ST_ACK_ADDR || state_r == ST_ACK_DATA);

  // protocol state, shifter and bit counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      cnt_r <= 4'h0;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_ADDR, ST_DATA: begin
          if (scl_rise && cnt_r != BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_sync_r[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            if (state_r == ST_DATA) begin
              state_r <= ST_ACK_DATA;
            end else if (addr_hit) begin
              state_r <= ST_ACK_ADDR;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_DATA: begin
          if (scl_fall) begin
            state_r <= ST_DATA;
            cnt_r <= 4'h0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge drive: low for the ninth clock of each accepted byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_r <= 1'h0;
    end else if (start_ev || stop_ev) begin
      oe_r <= 1'h0;
    end else if (ack_addr || ack_data) begin
      oe_r <= 1'h1;
    end else if (ack_end) begin
      oe_r <= 1'h0;
    end
  end

  // byte store in ascending order; bytes past the third are dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= {CFG_RST, CFG_RST, CFG_RST};
      idx_r <= 2'h0;
      written_r <= 1'h0;
    end else if (start_ev) begin
      idx_r <= 2'h0;
    end else if (ack_data && idx_r != NUM_CFG_BYTES) begin
      written_r <= 1'h1;
      idx_r <= idx_r + 2'h1;
      if (idx_r == IDX_LOW) begin
        cfg_r.low <= shift_r;
      end else if (idx_r == IDX_MID) begin
        cfg_r.mid <= shift_r;
      end else begin
        cfg_r.fb <= shift_r;
      end
    end
  end

  // decoded enables in the system domain
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_sys_r <= EN_ALL;
    end else begin
      en_sys_r <= cfb_map(cfg_r);
    end
  end

  // reset release synchronised to the fanned-out clock
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_ref_r <= 2'h3;
    end else begin
      rst_ref_r <= {rst_ref_r[0], 1'h0};
    end
  end

  // enable bits cross as independent levels
  always_ff @(posedge i_ref_clk or posedge rst_ref_r[1]) begin
    if (rst_ref_r[1]) begin
      en_m1_r <= EN_ALL;
      en_m2_r <= EN_ALL;
    end else begin
      en_m1_r <= en_sys_r;
      en_m2_r <= en_m1_r;
    end
  end

  // gate updates on the falling edge so outputs start and stop low
  always_ff @(negedge i_ref_clk or posedge rst_ref_r[1]) begin
    if (rst_ref_r[1]) begin
      gate_r <= EN_ALL;
    end else begin
      gate_r <= en_m2_r;
    end
  end

  // gated copies of the input clock
  assign o_mem_clk = {NUM_MEM{i_ref_clk}} & gate_r[NUM_MEM-1:0];
  assign o_feedback_clock_output = i_ref_clk & gate_r[NUM_MEM];
  assign o_serial_data_line_o = 1'h0;
  assign o_serial_data_line_oe = oe_r;

  a_msb_first: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == ST_DATA && scl_rise && cnt_r != BITS_PER_BYTE && !start_ev
     && !stop_ev) |=> shift_r[0] == $past(sda_sync_r[1]))
    else $error("data bit not shifted in msb first");
  a_addr_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == ST_ADDR && byte_done && !addr_hit && !start_ev && !stop_ev)
    |=> ((state_r == ST_IDLE) && !oe_r) [*2])
    else $error("foreign address was answered");
  a_addr_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    (ack_addr && !start_ev && !stop_ev) |=> oe_r && state_r == ST_ACK_ADDR)
    else $error("own address not acknowledged");
  a_map_low: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 en_sys_r[5:0] == {$past(cfg_r.low[7:6]), $past(cfg_r.low[3:0])})
    else $error("low byte enables wrong");
  a_map_mid: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 en_sys_r[11:6] == {$past(cfg_r.mid[7:4]), $past(cfg_r.mid[1:0])})
    else $error("mid byte enables wrong");
  a_map_fb: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 en_sys_r[12] == $past(cfg_r.fb[6]))
    else $error("feedback enable wrong");
  a_reset_on: assert property (@(posedge i_clk) disable iff (i_rst)
    !written_r |-> en_sys_r == EN_ALL)
    else $error("enables not all set before first write");
  a_store_order: assert property (@(posedge i_clk) disable iff (i_rst)
    (ack_data && idx_r == IDX_MID && !start_ev) |=> cfg_r.mid == $past(shift_r)
    && idx_r == IDX_FB)
    else $error("second byte not stored in mid group");
  a_data_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    (ack_data && !start_ev && !stop_ev) |=> oe_r ##1 (oe_r || ack_end
    || $past(ack_end) || start_ev || stop_ev))
    else $error("data byte not acknowledged");
  a_gate_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_mem_clk & ~gate_r[NUM_MEM-1:0]) == '0)
    else $error("disabled output not low");
  // sampled by the system clock: the gate holds across any high phase
  a_gate_edge: assert property (@(posedge i_clk)
    disable iff (i_rst || rst_ref_r[1])
    (i_ref_clk && $past(i_ref_clk)) |-> $stable(gate_r))
    else $error("gate changed in high phase");
  a_fanout: assert property (@(posedge i_clk) disable iff (i_rst)
    gate_r[NUM_MEM] |-> o_feedback_clock_output == i_ref_clk)
    else $error("feedback output not a copy of input clock");

  c_addr_ack: cover property (@(posedge i_clk) disable iff (i_rst) ack_addr);
  c_third_byte: cover property (@(posedge i_clk) disable iff (i_rst)
    ack_data && idx_r == IDX_FB);
  c_extra_byte: cover property (@(posedge i_clk) disable iff (i_rst)
    ack_data && idx_r == NUM_CFG_BYTES);
  c_fb_off: cover property (@(posedge i_ref_clk) disable iff (rst_ref_r[1])
    !gate_r[NUM_MEM]);
endmodule

/* File: rtl/cfb_pkg.sv */
/*
  Constants, types and the enable-decoding function for the clock fanout
  buffer with its two-wire enable port.
  Assumes one system clock for the serial slave and a free-running input
  clock for the output gating.
*/
package cfb_pkg;
  localparam int NUM_OUT = 13;                   // total gated outputs
  localparam int NUM_MEM = 12;                   // outputs for memory modules
  localparam logic [6:0] DEV_ADDR = 7'h69;       // slave address 1101001
  localparam logic DIR_WRITE = 1'h0;             // direction bit of a write
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] NUM_CFG_BYTES = 2'h3;
  localparam logic [1:0] IDX_LOW = 2'h0;         // output_enable_low_group
  localparam logic [1:0] IDX_MID = 2'h1;         // output_enable_mid_group
  localparam logic [1:0] IDX_FB = 2'h2;          // output_enable_feedback
  localparam logic [7:0] CFG_RST = 8'hFF;        // every enable set
  localparam logic [NUM_OUT-1:0] EN_ALL = 13'h1FFF;
  // bit positions inside the configuration bytes
  localparam int LOW_A_LSB = 0;                  // bits 3:0 -> outputs 3:0
  localparam int LOW_B_LSB = 6;                  // bits 7:6 -> outputs 5:4
  localparam int MID_A_LSB = 0;                  // bits 1:0 -> outputs 7:6
  localparam int MID_B_LSB = 4;                  // bits 7:4 -> outputs 11:8
  localparam int FB_BIT = 6;                     // bit 6 -> output 12

  typedef struct packed {
    logic [7:0] fb;
    logic [7:0] mid;
    logic [7:0] low;
  } cfb_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_DATA,
    ST_ACK_DATA
  } cfb_state_e;

  // gather the functional bits of the three bytes into one enable vector
  function automatic logic [NUM_OUT-1:0] cfb_map(input cfb_cfg_s c);
    logic [NUM_OUT-1:0] e;
    e = '0;
    e[3:0] = c.low[LOW_A_LSB +: 4];
    e[5:4] = c.low[LOW_B_LSB +: 2];
    e[7:6] = c.mid[MID_A_LSB +: 2];
    e[11:8] = c.mid[MID_B_LSB +: 4];
    e[12] = c.fb[FB_BIT];
    return e;
  endfunction
endpackage
